/* design/pspcr_delay_if.sv */
// link between the register bank and its blanking / sync delay timer
`timescale 1ns/100ps
interface pspcr_delay_if;
  logic start;
  logic [7:0] count;
  logic [1:0] div_sel;
  logic step;
  logic busy;
  logic done;
  modport ctrl (output start, output count, output div_sel, output step, input busy, input done);
  modport timer (input start, input count, input div_sel, input step, output busy, output done);
endinterface

/* design/pspcr_delay_timer.sv */
// blanking window and analog sync delay timer, counted on controller steps
`timescale 1ns/100ps
module pspcr_delay_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control side
  pspcr_delay_if.timer dl
);
  typedef struct packed {
    logic [7:0] left;
    logic [2:0] div_cnt;
    logic busy;
    logic done;
  } pspcr_timer_state_t;

  pspcr_timer_state_t st;
  pspcr_timer_state_t next_st;
  logic [2:0] mask;
  logic tick;

  // --------------------------------------------------------------
  // tick divider: step divided by 1, 2, 4 or 8
  // --------------------------------------------------------------
  always_comb begin
    mask = 3'((4'h1 << dl.div_sel) - 4'h1);
    tick = dl.step && ((st.div_cnt & mask) == mask);
  end

  // --------------------------------------------------------------
  // countdown; a fresh start restarts a running window
  // --------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (dl.step) begin
      next_st.div_cnt = st.div_cnt + 3'h1;
    end
    if (dl.start) begin
      next_st.div_cnt = 3'h0;
      next_st.left = dl.count;
      next_st.busy = (dl.count != 8'h00);
      next_st.done = (dl.count == 8'h00); // zero delay passes at once
    end else if (st.busy && tick) begin
      next_st.left = st.left - 8'h01;
      if (st.left == 8'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dl.busy = st.busy;
  assign dl.done = st.done;
endmodule

/* design/pspcr_pkg.sv */
// shared constants of the power stage compare and configuration register bank
package pspcr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_RA_H = 5'h00;
  localparam logic [4:0] OFS_RA_L = 5'h01;
  localparam logic [4:0] OFS_SA_H = 5'h02;
  localparam logic [4:0] OFS_SA_L = 5'h03;
  localparam logic [4:0] OFS_SB_H = 5'h04;
  localparam logic [4:0] OFS_SB_L = 5'h05;
  localparam logic [4:0] OFS_RB_H = 5'h06;
  localparam logic [4:0] OFS_RB_L = 5'h07;
  localparam logic [4:0] OFS_CNF = 5'h08;
  localparam logic [4:0] OFS_CNFE = 5'h09;
  localparam logic [4:0] OFS_CTRL = 5'h0A;
  localparam logic [4:0] OFS_OCFG = 5'h0B;
  localparam logic [4:0] OFS_MTX = 5'h0C;
  localparam logic [4:0] OFS_DLY = 5'h0D;
  localparam logic [4:0] OFS_INA = 5'h0E;
  localparam logic [4:0] OFS_INB = 5'h0F;
  localparam logic [4:0] OFS_STAT = 5'h10;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CNF_FIFTY = 7;
  localparam int CNF_ALOCK = 6;
  localparam int CNF_LOCK = 5;
  localparam int CNF_MODE_HI = 4;
  localparam int CNF_MODE_LO = 3;
  localparam int CNF_POL = 2;
  localparam int CNF_CLKSEL = 1;
  localparam int CNF_MTX_EN = 0;
  localparam int CNFE_BD_HI = 7;
  localparam int CNFE_BD_LO = 5;
  localparam int CNFE_FLANK_UP = 4;
  localparam int CNFE_EDGE_A_UP = 3;
  localparam int CNFE_EDGE_B_UP = 2;
  localparam int CNFE_SRC_A_UP = 1;
  localparam int CNFE_SRC_B_UP = 0;
  localparam int CTRL_FLANK_LO = 5;
  localparam int IN_SRC_LO = 6;
  localparam int IN_EDGE_LO = 5;
  localparam int OCFG_SEL_D = 7;
  localparam int OCFG_SEL_C = 6;
  localparam int OCFG_SYNC_HI = 5;
  localparam int OCFG_SYNC_LO = 4;
  localparam int OCFG_EN_D = 3;
  localparam int OCFG_EN_B = 2;
  localparam int OCFG_EN_C = 1;
  localparam int OCFG_EN_A = 0;
  localparam int CMP_W = 12;
  localparam int FLANK_W = 4;
  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] MODE_ONE_RAMP = 2'h0;
  localparam logic [1:0] MODE_CENTRE = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_TOGGLE = 2'h2;
  localparam logic [2:0] BD_NONE = 3'h0;
  localparam logic [2:0] BD_BLANK_END = 3'h1;
  localparam logic [2:0] BD_BLANK_SA = 3'h2;
  localparam logic [2:0] BD_BLANK_SB = 3'h3;
endpackage

/* design/pspcr_regs.sv */
// compare and configuration register bank of one power stage controller
// Notes on behaviour
// - four 12-bit compares matched on each step
// - reset-B carries 4-bit flank value in 15:12
// - one shared high-byte latch, atomic update
// - fifty mode copies B values into A
// - autolock commits at cycle end after RB
// - autolock wins over lock
// - lock buffers compares, OCFG and MTX until lock cleared
// - mode field selects ramp or centre counting
// - polarity bit: clear low, set high
// - clock select: set fast, clear slow
// - matrix enable overrides polarity
// - codes 1-3 blank from cycle end/SA/SB
// - codes 4-7 delay sync, divide 1/2/4/8
// - flank mode picks modulated compare edges
// - one-ramp SA modulation alters on-time
// - lower flank bit lives in control bit 5
// - edge select: fall, rise, toggle, reserved
// - source select: pin, cmp1, alt pin, cmp2
// - 8-bit delay count for blank and sync
`timescale 1ns/100ps
module pspcr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [pspcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // counter core
  input wire logic fast_clock_input,
  input wire logic slow_clock_input,
  input wire logic [11:0] count_val,
  input wire logic cycle_end,
  input wire logic wave_a,
  input wire logic wave_b,
  output logic ctrl_step,
  output logic input_clock_select,
  output logic [1:0] ramp_mode_select,
  output logic [11:0] active_reset_a,
  output logic [11:0] active_set_a,
  output logic [11:0] active_set_b,
  output logic [15:0] active_reset_b,
  output logic [3:0] match,
  output logic [3:0] flank_targets,
  output logic ontime_affected,
  // retrigger / fault inputs
  input wire logic primary_input_pin,
  input wire logic alternate_input_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  output logic [1:0] input_event,
  output logic blank_active,
  // pins and adc
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe,
  output logic adc_sync
);
  typedef struct packed {
    logic [7:0] temp;
    logic [11:0] sh_ra;
    logic [11:0] sh_sa;
    logic [11:0] sh_sb;
    logic [15:0] sh_rb;
    logic [7:0] sh_ocfg;
    logic [7:0] sh_mtx;
    logic [11:0] ra;
    logic [11:0] sa;
    logic [11:0] sb;
    logic [15:0] rb;
    logic [7:0] ocfg;
    logic [7:0] mtx;
    logic [7:0] cnf;
    logic [7:0] cnfe;
    logic [7:0] ctl;
    logic [7:0] dly;
    logic [7:0] ina;
    logic [7:0] inb;
    logic lock_dirty;
    logic alock_dirty;
    logic last_rb;
    logic [7:0] rdata;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] prev_in;
    logic [1:0] evt;
    logic [3:0] out;
    logic [3:0] oe;
    logic adc;
  } pspcr_state_t;

  pspcr_state_t st;
  pspcr_state_t n;
  pspcr_delay_if dl ();
  logic step;
  logic [3:0] m;
  logic [1:0] raw_evt;
  logic [1:0] flank_mode;
  logic [2:0] bd_mode;
  logic sync_src;
  logic commit;
  logic lock_now;
  logic alock_now;
  logic [7:0] lo;

  // ----------------------------------------------------------------
  // controller step and compare matches
  // ----------------------------------------------------------------
  always_comb begin
    step = st.cnf[pspcr_pkg::CNF_CLKSEL] ? fast_clock_input : slow_clock_input;
    m[0] = step && (count_val == st.ra);
    m[1] = step && (count_val == st.sa);
    m[2] = step && (count_val == st.sb);
    m[3] = step && (count_val == st.rb[pspcr_pkg::CMP_W-1:0]);
  end

  // ----------------------------------------------------------------
  // edge event per input part: fall, rise or toggle
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_part
    logic [1:0] src_sel;
    logic [1:0] edge_sel;
    logic cur;
    always_comb begin
      src_sel = (i == 0)
        ? {st.cnfe[pspcr_pkg::CNFE_SRC_A_UP], st.ina[pspcr_pkg::IN_SRC_LO]}
        : {st.cnfe[pspcr_pkg::CNFE_SRC_B_UP], st.inb[pspcr_pkg::IN_SRC_LO]};
      edge_sel = (i == 0)
        ? {st.cnfe[pspcr_pkg::CNFE_EDGE_A_UP], st.ina[pspcr_pkg::IN_EDGE_LO]}
        : {st.cnfe[pspcr_pkg::CNFE_EDGE_B_UP], st.inb[pspcr_pkg::IN_EDGE_LO]};
      cur = st.sync2[src_sel];
      unique case (edge_sel)
        pspcr_pkg::EDGE_FALL: raw_evt[i] = st.prev_in[i] && !cur;
        pspcr_pkg::EDGE_RISE: raw_evt[i] = !st.prev_in[i] && cur;
        pspcr_pkg::EDGE_TOGGLE: raw_evt[i] = st.prev_in[i] != cur;
        default: raw_evt[i] = 1'b0; // reserved code raises nothing
      endcase
    end
  end

  // ----------------------------------------------------------------
  // blanking and sync delay control
  // ----------------------------------------------------------------
  always_comb begin
    bd_mode = st.cnfe[pspcr_pkg::CNFE_BD_HI:pspcr_pkg::CNFE_BD_LO];
    if (st.cnf[pspcr_pkg::CNF_MODE_HI:pspcr_pkg::CNF_MODE_LO] == pspcr_pkg::MODE_CENTRE) begin
      sync_src = !st.ocfg[pspcr_pkg::OCFG_SYNC_HI] && m[0]; // centre: RA match or none
    end else begin
      unique case (st.ocfg[pspcr_pkg::OCFG_SYNC_HI:pspcr_pkg::OCFG_SYNC_LO])
        2'h0: sync_src = m[1];
        2'h1: sync_src = m[0];
        2'h2: sync_src = m[2];
        2'h3: sync_src = m[3];
      endcase
    end

    dl.step = step;
    dl.count = st.dly;
    dl.div_sel = bd_mode[1:0];

    unique case (bd_mode)
      pspcr_pkg::BD_NONE: dl.start = 1'b0;
      pspcr_pkg::BD_BLANK_END: dl.start = cycle_end;
      pspcr_pkg::BD_BLANK_SA: dl.start = m[1];
      pspcr_pkg::BD_BLANK_SB: dl.start = m[2];
      default: dl.start = sync_src; // delayed sync
    endcase
  end

  pspcr_delay_timer u_timer (
    .clk_sys (clk_sys),
    .srst (srst),
    .dl (dl)
  );

  // ----------------------------------------------------------------
  // next state: register writes, buffering, pins
  // ----------------------------------------------------------------
  always_comb begin
    n = st;
    lo = reg_wdata;
    lock_now = st.cnf[pspcr_pkg::CNF_LOCK];
    alock_now = st.cnf[pspcr_pkg::CNF_ALOCK];
    commit = 1'b0;

    // two-stage synchroniser on outside inputs
    n.sync1 = {cmp2_out, alternate_input_pin, cmp1_out, primary_input_pin};
    n.sync2 = st.sync1;
    n.prev_in = {g_part[1].cur, g_part[0].cur};
    n.evt = raw_evt & {2{!dl.busy}}; // blanked while the window runs

    if (reg_we) begin
      unique case (reg_addr)
        pspcr_pkg::OFS_RA_H, pspcr_pkg::OFS_SA_H,
        pspcr_pkg::OFS_SB_H, pspcr_pkg::OFS_RB_H: n.temp = reg_wdata;
        pspcr_pkg::OFS_RA_L: begin
          n.sh_ra = {st.temp[3:0], lo};
          n.last_rb = 1'b0;
        end
        pspcr_pkg::OFS_SA_L: begin
          n.sh_sa = {st.temp[3:0], lo};
          n.last_rb = 1'b0;
        end
        pspcr_pkg::OFS_SB_L: begin
          n.sh_sb = {st.temp[3:0], lo};
          n.last_rb = 1'b0;
        end
        pspcr_pkg::OFS_RB_L: begin
          n.sh_rb = {st.temp, lo}; // flank value rides in 15:12
          n.last_rb = 1'b1;
          n.alock_dirty = alock_now;
        end
        pspcr_pkg::OFS_OCFG: begin
          n.sh_ocfg = reg_wdata;
          n.last_rb = 1'b0;
        end
        pspcr_pkg::OFS_MTX: begin
          n.sh_mtx = reg_wdata;
          n.last_rb = 1'b0;
        end
        pspcr_pkg::OFS_CNF: n.cnf = reg_wdata;
        pspcr_pkg::OFS_CNFE: n.cnfe = reg_wdata;
        pspcr_pkg::OFS_CTRL: n.ctl = reg_wdata;
        pspcr_pkg::OFS_DLY: n.dly = reg_wdata;
        pspcr_pkg::OFS_INA: n.ina = reg_wdata;
        pspcr_pkg::OFS_INB: n.inb = reg_wdata;
        default: ;
      endcase
    end

    // buffered writes under lock, marked for the later release
    if (reg_we && lock_now && !alock_now && (reg_addr inside {pspcr_pkg::OFS_RA_L,
        pspcr_pkg::OFS_SA_L, pspcr_pkg::OFS_SB_L, pspcr_pkg::OFS_RB_L,
        pspcr_pkg::OFS_OCFG, pspcr_pkg::OFS_MTX})) begin
      n.lock_dirty = 1'b1;
    end

    // choose when the shadow set reaches the running registers
    if (alock_now) begin
      commit = cycle_end && n.last_rb && n.alock_dirty;
    end else if (lock_now) begin
      commit = st.lock_dirty && !n.cnf[pspcr_pkg::CNF_LOCK]; // release applies
    end else begin
      commit = reg_we && (reg_addr inside {pspcr_pkg::OFS_RA_L, pspcr_pkg::OFS_SA_L,
        pspcr_pkg::OFS_SB_L, pspcr_pkg::OFS_RB_L, pspcr_pkg::OFS_OCFG, pspcr_pkg::OFS_MTX});
    end

    if (commit) begin
      n.ra = n.sh_ra;
      n.sa = n.sh_sa;
      n.sb = n.sh_sb;
      n.rb = n.sh_rb;
      n.ocfg = n.sh_ocfg;
      n.mtx = n.sh_mtx;
      n.lock_dirty = 1'b0;
      n.alock_dirty = 1'b0;
      if (st.cnf[pspcr_pkg::CNF_FIFTY]) begin
        n.ra = n.sh_rb[pspcr_pkg::CMP_W-1:0]; // copy on every commit
        n.sa = n.sh_sb;
      end
    end

    // pins: matrix bypasses polarity, else polarity per wave
    if (st.cnf[pspcr_pkg::CNF_MTX_EN]) begin
      n.out = wave_b ? st.mtx[7:4] : st.mtx[3:0];
    end else begin
      n.out[0] = st.cnf[pspcr_pkg::CNF_POL] ? wave_a : !wave_a;
      n.out[1] = st.cnf[pspcr_pkg::CNF_POL] ? wave_b : !wave_b;
      n.out[2] = (st.ocfg[pspcr_pkg::OCFG_SEL_C] ? wave_b : wave_a) ~^ st.cnf[pspcr_pkg::CNF_POL];
      n.out[3] = (st.ocfg[pspcr_pkg::OCFG_SEL_D] ? wave_a : wave_b) ~^ st.cnf[pspcr_pkg::CNF_POL];
    end

    n.oe = {st.ocfg[pspcr_pkg::OCFG_EN_D], st.ocfg[pspcr_pkg::OCFG_EN_C],
            st.ocfg[pspcr_pkg::OCFG_EN_B], st.ocfg[pspcr_pkg::OCFG_EN_A]};

    // sync straight through, or the timer end in delay codes
    n.adc = bd_mode[2] ? dl.done : sync_src;

    // read data valid in the cycle after the strobe only
    n.rdata = 8'h00;
    if (reg_re) begin
      unique case (reg_addr)
        pspcr_pkg::OFS_CNF: n.rdata = st.cnf;
        pspcr_pkg::OFS_CNFE: n.rdata = st.cnfe;
        pspcr_pkg::OFS_CTRL: n.rdata = st.ctl;
        pspcr_pkg::OFS_OCFG: n.rdata = st.ocfg;
        pspcr_pkg::OFS_MTX: n.rdata = st.mtx;
        pspcr_pkg::OFS_INA: n.rdata = st.ina;
        pspcr_pkg::OFS_INB: n.rdata = st.inb;
        pspcr_pkg::OFS_STAT: n.rdata = {2'h0, st.evt, dl.busy, st.last_rb, st.alock_dirty, st.lock_dirty};
        default: n.rdata = 8'h00; // write-only and unmapped read zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // ----------------------------------------------------------------
  // flank width decode and outputs
  // ----------------------------------------------------------------
  always_comb begin
    flank_mode = {st.cnfe[pspcr_pkg::CNFE_FLANK_UP], st.ctl[pspcr_pkg::CTRL_FLANK_LO]};
    unique case (flank_mode)
      2'h0: flank_targets = 4'h8; // RB only
      2'h1: flank_targets = 4'h9; // RB and RA
      2'h2: flank_targets = 4'h4; // SB only
      2'h3: flank_targets = 4'h6; // SB and SA
    endcase

    // SA shift moves the on-time edge in one-ramp counting
    ontime_affected = (ramp_mode_select == pspcr_pkg::MODE_ONE_RAMP) && (flank_mode == 2'h3);
  end

  assign ctrl_step = step;
  assign input_clock_select = st.cnf[pspcr_pkg::CNF_CLKSEL];
  assign ramp_mode_select = st.cnf[pspcr_pkg::CNF_MODE_HI:pspcr_pkg::CNF_MODE_LO];
  assign active_reset_a = st.ra;
  assign active_set_a = st.sa;
  assign active_set_b = st.sb;
  assign active_reset_b = st.rb;
  assign match = m;
  assign input_event = st.evt;
  assign blank_active = dl.busy;
  assign pwm_out = st.out;
  assign pwm_oe = st.oe;
  assign adc_sync = st.adc;
  assign reg_rdata = st.rdata;
endmodule

/* verification/pspcr_regs_assertions.sv */
// port-side assertions of the compare and configuration register bank
`timescale 1ns/100ps
module pspcr_regs_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [pspcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata,
  // counter core
  input wire logic fast_clock_input,
  input wire logic slow_clock_input,
  input wire logic [11:0] count_val,
  input wire logic cycle_end,
  input wire logic ctrl_step,
  input wire logic input_clock_select,
  input wire logic [1:0] ramp_mode_select,
  input wire logic [11:0] active_reset_a,
  input wire logic [11:0] active_set_a,
  input wire logic [11:0] active_set_b,
  input wire logic [15:0] active_reset_b,
  input wire logic [3:0] match,
  input wire logic [3:0] flank_targets,
  input wire logic ontime_affected
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ----
  // helper state
  // ----
  // copy of the configuration byte, since the hold bits reach no port
  logic [7:0] cnf_seen;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnf_seen <= 8'h00;
    end else if (reg_we && reg_addr == pspcr_pkg::OFS_CNF) begin
      cnf_seen <= reg_wdata;
    end
  end
  // high then low byte of reset-b on back-to-back writes
  sequence rb_pair;
    reg_we && reg_addr == pspcr_pkg::OFS_RB_H ##1 reg_we && reg_addr == pspcr_pkg::OFS_RB_L;
  endsequence
  // ----
  // assertions
  // ----
  a_match_all: assert property (
    match == ({4{ctrl_step}} & {count_val == active_reset_b[11:0], count_val == active_set_b,
      count_val == active_set_a, count_val == active_reset_a}))
    else $error("match pulses disagree with compare values");
  a_step_select: assert property (
    ctrl_step == (input_clock_select ? fast_clock_input : slow_clock_input))
    else $error("step enable from wrong clock input");
  a_mode_field: assert property (
    reg_we && reg_addr == pspcr_pkg::OFS_CNF |=> ramp_mode_select == cnf_seen[4:3]
      && input_clock_select == cnf_seen[1])
    else $error("mode or clock select not taken from config write");
  a_rb_commit: assert property (
    (rb_pair ##0 cnf_seen[6:5] == 2'h0) |=> active_reset_b == {$past(reg_wdata, 2), $past(reg_wdata)})
    else $error("reset-b pair not committed together");
  a_fifty_copy: assert property (
    (rb_pair ##0 cnf_seen[7:5] == 3'h4) |=> active_reset_a == active_reset_b[11:0]
      && active_set_a == active_set_b)
    else $error("fifty mode did not copy b values");
  a_lock_hold: assert property (
    cnf_seen[6:5] == 2'h1 && reg_we && reg_addr[4:3] == 2'h0 && reg_addr[0]
    |=> $stable(active_reset_a) && $stable(active_set_a) && $stable(active_set_b) && $stable(active_reset_b))
    else $error("compare changed while held");
  a_alock_hold: assert property (
    cnf_seen[6] && !cycle_end && reg_we && reg_addr == pspcr_pkg::OFS_SA_L |=> $stable(active_set_a))
    else $error("set-a applied outside cycle end");
  a_flank_code: assert property (
    flank_targets inside {4'h8, 4'h9, 4'h4, 4'h6})
    else $error("flank target code illegal");
  a_ontime_mode: assert property (
    ontime_affected == (ramp_mode_select == 2'h0 && flank_targets == 4'h6))
    else $error("on-time flag wrong");
  a_rdata_idle: assert property (
    !reg_re || reg_addr <= pspcr_pkg::OFS_RB_L |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_reset_clear: assert property (
    $fell(srst) |-> active_reset_b == 16'h0000 && active_reset_a == 12'h000 && ramp_mode_select == 2'h0)
    else $error("state not cleared by reset");
endmodule

/* verification/tb.sv */
// self-checking bench of the compare and configuration register bank
`timescale 1ns/100ps
module tb;
  // ----
  // design ports and bench state
  // ----
  logic clk_sys, srst, reg_we, reg_re, fast_clock_input, slow_clock_input, cycle_end, wave_a, wave_b;
  logic primary_input_pin, alternate_input_pin, cmp1_out, cmp2_out, ctrl_step, input_clock_select;
  logic ontime_affected, blank_active, adc_sync;
  logic [pspcr_pkg::ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [11:0] count_val, active_reset_a, active_set_a, active_set_b;
  logic [15:0] active_reset_b;
  logic [1:0] ramp_mode_select, input_event;
  logic [3:0] match, flank_targets, pwm_out, pwm_oe;
  logic [3:0] ftab [4] = '{4'h8, 4'h9, 4'h4, 4'h6};
  logic [4:0] probe [4] = '{pspcr_pkg::OFS_CNF, pspcr_pkg::OFS_CNFE, pspcr_pkg::OFS_RA_H, 5'h1F};
  logic [31:0] seed = 32'h00010E04;
  int failures = 0;
  int cmp_count = 0;
  pspcr_regs uut (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .fast_clock_input,
    .slow_clock_input, .count_val, .cycle_end, .wave_a, .wave_b, .ctrl_step, .input_clock_select,
    .ramp_mode_select, .active_reset_a, .active_set_a, .active_set_b, .active_reset_b, .match, .flank_targets,
    .ontime_affected, .primary_input_pin, .alternate_input_pin, .cmp1_out, .cmp2_out, .input_event,
    .blank_active, .pwm_out, .pwm_oe, .adc_sync);
  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] act(input int k);
    case (k)
      0: return {4'h0, active_reset_a};
      1: return {4'h0, active_set_a};
      2: return {4'h0, active_set_b};
      default: return active_reset_b;
    endcase
  endfunction
  // only reset-b keeps the upper nibble of its high byte
  function automatic logic [15:0] cmp_exp(input int k, input logic [7:0] h, input logic [7:0] l);
    return (k == 3) ? {h, l} : {4'h0, h[3:0], l};
  endfunction
  function automatic logic [3:0] pin_exp(input int m, input logic [1:0] w, input logic [7:0] mx);
    return (m == 2) ? (w[1] ? mx[7:4] : mx[3:0]) : ((m == 1) ? {w, w} : ~{w, w});
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobe stays high for back-to-back writes; idle drops it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic idle();
    reg_we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic wpair(input int k, input logic [15:0] v);
    wr(pspcr_pkg::OFS_RA_H + 5'(2 * k), v[15:8]);
    wr(pspcr_pkg::OFS_RA_H + 5'(2 * k + 1), v[7:0]);
    idle();
  endtask
  task automatic end_cycle();
    cycle_end <= 1'b1;
    @(posedge clk_sys);
    cycle_end <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [7:0] v, r;
    logic [15:0] sa, rb;
    logic [31:0] t;
    int n;
    {reg_we, reg_re, fast_clock_input, slow_clock_input, cycle_end, wave_a, wave_b} = 7'h00;
    {primary_input_pin, alternate_input_pin, cmp1_out, cmp2_out} = 4'h0;
    {reg_addr, reg_wdata, count_val} = 25'h0000000;
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    // reset values; write-only and unmapped read zero
    wr(5'h1F, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      rd(probe[i], r);
      check({8'h00, r}, 16'h0000);
      check(act(i), 16'h0000);
    end
    $display("reset test done");
    // configuration read back, every ramp mode and step from the fast clock input
    for (int i = 0; i < 8; i++) begin
      t = rnd();
      v = {t[7], 2'h0, 2'(i), t[2:0]};
      wr(pspcr_pkg::OFS_CNF, v);
      wr(pspcr_pkg::OFS_CNFE, t[15:8]);
      rd(pspcr_pkg::OFS_CNF, r);
      check({8'h00, r}, {8'h00, v});
      rd(pspcr_pkg::OFS_CNFE, r);
      check({8'h00, r}, {8'h00, t[15:8]});
      check({14'h0000, ramp_mode_select}, {14'h0000, v[4:3]});
      fast_clock_input <= 1'b1;
      @(posedge clk_sys);
      check({15'h0000, ctrl_step}, {15'h0000, v[1]});
      fast_clock_input <= 1'b0;
    end
    $display("config test done");
    // compare pairs through the shared high byte, then matches on slow steps
    wr(pspcr_pkg::OFS_CNF, 8'h00);
    for (int k = 0; k < 4; k++) begin
      t = rnd();
      wpair(k, t[15:0]);
      check(act(k), cmp_exp(k, t[15:8], t[7:0]));
    end
    slow_clock_input <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      sa = act(k);
      count_val <= sa[11:0];
      @(posedge clk_sys);
      check({15'h0000, match[k]}, 16'h0001);
    end
    slow_clock_input <= 1'b0;
    $display("compare test done");
    // fifty mode copies b values into a
    t = rnd();
    wr(pspcr_pkg::OFS_CNF, 8'h80);
    wpair(2, t[15:0]);
    wpair(3, t[31:16]);
    check(act(0), {4'h0, t[27:16]});
    check(act(1), {4'h0, t[11:0]});
    // hold: nothing moves until the hold bit is cleared
    wr(pspcr_pkg::OFS_CNF, 8'h20);
    sa = act(0);
    t = rnd();
    wr(pspcr_pkg::OFS_OCFG, 8'h05);
    wpair(0, t[15:0]);
    check(act(0), sa);
    wr(pspcr_pkg::OFS_CNF, 8'h00);
    idle();
    check(act(0), {4'h0, t[11:0]});
    // auto hold wins over hold; applies at cycle end only after reset-b
    wr(pspcr_pkg::OFS_CNF, 8'h60);
    check({12'h000, pwm_oe}, 16'h0003);
    sa = act(1);
    t = rnd();
    wpair(3, t[15:0]);
    wpair(1, t[31:16]);
    end_cycle();
    check(act(1), sa);
    wpair(3, t[15:0]);
    check(act(1), sa);
    end_cycle();
    check(act(1), {4'h0, t[27:16]});
    check(act(3), t[15:0]);
    wr(pspcr_pkg::OFS_CNF, 8'h00);
    $display("update test done");
    // flank selection from both halves of the mode pair
    for (int f = 0; f < 4; f++) begin
      wr(pspcr_pkg::OFS_CNFE, {3'h0, f[1], 4'h0});
      wr(pspcr_pkg::OFS_CTRL, {2'h0, f[0], 5'h00});
      idle();
      check({12'h000, flank_targets}, {12'h000, ftab[f]});
      check({15'h0000, ontime_affected}, {15'h0000, 1'(f == 3)});
    end
    $display("flank test done");
    // polarity low, polarity high, then matrix overriding polarity
    r = 8'(rnd());
    wr(pspcr_pkg::OFS_MTX, r);
    for (int m = 0; m < 3; m++) begin
      wr(pspcr_pkg::OFS_CNF, (m == 0) ? 8'h00 : ((m == 1) ? 8'h04 : 8'h05));
      for (int i = 0; i < 4; i++) begin
        {wave_b, wave_a} <= 2'(i);
        idle();
        idle();
        check({12'h000, pwm_out}, {12'h000, pin_exp(m, 2'(i), r)});
      end
    end
    $display("output test done");
    // edge codes on part a: fall, rise, toggle, reserved gives nothing
    primary_input_pin <= 1'b1;
    for (int e = 0; e < 4; e++) begin
      wr(pspcr_pkg::OFS_CNFE, {4'h0, e[1], 3'h0});
      wr(pspcr_pkg::OFS_INA, {2'h0, e[0], 5'h00});
      idle();
      primary_input_pin <= e[0];
      n = 0;
      repeat (8) begin
        @(posedge clk_sys);
        n = n + int'(input_event[0]);
      end
      check(16'(n > 0), 16'(e != 3));
    end
    $display("input test done");
    conclude();
  end
  // cut a hang short past the expected run length
  initial begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    conclude();
  end
endmodule
bind pspcr_regs pspcr_regs_checker u_chk (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
  .fast_clock_input, .slow_clock_input, .count_val, .cycle_end, .ctrl_step, .input_clock_select,
  .ramp_mode_select, .active_reset_a, .active_set_a, .active_set_b, .active_reset_b, .match, .flank_targets,
  .ontime_affected);
